// ===== verilog/iwd_watchdog.sv
// I/O port watchdog timer with reset or interrupt expiry action
// Notes on behaviour
// (RULE1) A write of 1 to the port arms the timer and restarts the full interval.
// (RULE2) The first read of the port enables the timer.
// (RULE3) Software must keep writing 1 with every gap shorter than the timeout.
// (RULE4) An enabled timer that sees no refresh before timeout asserts CPU reset or interrupt, as the strap selects.
// (RULE5) A write of 0 disables the timer and stops all timeout actions.
// (RULE6) The expiry action is CPU reset or interrupt, reset by default.
// (RULE7) Out of reset the expiry action is tied to CPU reset.
// (RULE8) The real period may stray thirty percent from nominal; it is a parameter.
// (RULE9) Software should refresh about once per second.
// (RULE10) A disabled timer holds idle; each refresh counts a full interval again.
`timescale 1ns/1ps
module iwd_watchdog
  import iwd_pkg::*;
#(
  parameter int TIMEOUT_TICKS = IWD_TIMEOUT_TICKS, // RULE8
  parameter int TICK_CYC      = IWD_TICK_CYC,
  parameter int RST_PULSE_CYC = IWD_RST_PULSE_CYC
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // I/O port access, one-cycle strobes
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  output logic [7:0]       o_io_rdata,
  // Action select strap, level
  input  wire logic        i_act_irq_sel,
  // Expiry outputs and enable status
  output logic             o_cpu_rst,
  output logic             o_irq,
  output logic             o_enabled
);
  iwd_state_type state_q;
  logic [31:0]   ticks_q;
  logic [7:0]    pulse_q;
  logic          sel_s1_q;
  logic          sel_q;

  wire hit     = (i_io_addr == IWD_PORT_ADDR);
  wire wr_hit  = i_io_wr && hit;
  wire rd_hit  = i_io_rd && hit;
  wire do_ref  = wr_hit && (i_io_wdata == IWD_CMD_REFRESH); // RULE1
  wire do_dis  = wr_hit && (i_io_wdata == IWD_CMD_DISABLE); // RULE5
  wire do_arm  = do_ref || (rd_hit && state_q == IWD_IDLE); // RULE2
  wire tick;
  wire expired = (state_q == IWD_RUN) && tick && (ticks_q == 32'(TIMEOUT_TICKS - 1));
  wire pulse_last = (pulse_q == 8'(RST_PULSE_CYC - 1));

  iwd_tick #(
    .DIV(TICK_CYC)
  ) u_tick (
    .i_ref_clk(i_ref_clk),
    .i_rst    (i_rst),
    .i_restart(do_arm),
    .o_tick   (tick)
  );

  // Strap synchroniser; default action is reset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sel_s1_q <= IWD_ACT_RESET; // RULE7
      sel_q    <= IWD_ACT_RESET;
    end else begin
      sel_s1_q <= i_act_irq_sel;
      sel_q    <= sel_s1_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q <= IWD_IDLE;
      ticks_q <= '0;
    end else if (do_dis) begin
      state_q <= IWD_IDLE; // RULE5
      ticks_q <= '0;
    end else if (do_arm) begin
      state_q <= IWD_RUN; // RULE1 RULE10
      ticks_q <= '0;
    end else begin
      case (state_q)
        IWD_IDLE: begin
          ticks_q <= '0; // RULE10
        end
        IWD_RUN: begin
          if (expired) begin
            state_q <= IWD_FIRE; // RULE4
            ticks_q <= '0;
          end else if (tick) begin
            ticks_q <= ticks_q + 32'h1;
          end
        end
        IWD_FIRE: begin
          if (pulse_last) begin
            state_q <= IWD_IDLE;
          end
        end
        default: state_q <= IWD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || state_q != IWD_FIRE) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= pulse_q + 8'h1;
    end
  end

  wire fire_next = (state_q == IWD_FIRE) && !do_dis && !do_arm
                   && !pulse_last;
  wire fire_now  = expired && !do_dis && !do_arm;
  wire act       = fire_now || fire_next;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cpu_rst  <= 1'b0;
      o_irq      <= 1'b0;
      o_enabled  <= 1'b0;
      o_io_rdata <= '0;
    end else begin
      o_cpu_rst  <= act && (sel_q == IWD_ACT_RESET); // RULE4 RULE6
      o_irq      <= act && (sel_q == IWD_ACT_IRQ); // RULE6
      o_enabled  <= !do_dis && (do_arm || state_q == IWD_RUN);
      o_io_rdata <= rd_hit ? {7'h00, state_q == IWD_RUN} : 8'h00;
    end
  end

  property p_dis_quiet;
    @(posedge i_ref_clk) disable iff (i_rst)
      do_dis |=> !o_enabled ##1 (!o_cpu_rst && !o_irq);
  endproperty
  a_dis_quiet: assert property (p_dis_quiet) else $error("watchdog acts after disable"); // RULE5

  property p_arm;
    @(posedge i_ref_clk) disable iff (i_rst)
      (do_ref && !do_dis) |=> o_enabled;
  endproperty
  a_arm: assert property (p_arm) else $error("refresh did not enable"); // RULE1

  property p_rd_arm;
    @(posedge i_ref_clk) disable iff (i_rst)
      (rd_hit && !wr_hit && state_q == IWD_IDLE) |=> state_q == IWD_RUN;
  endproperty
  a_rd_arm: assert property (p_rd_arm) else $error("read did not enable"); // RULE2

  sequence s_fire;
    expired && !do_dis && !do_arm && sel_q == IWD_ACT_RESET;
  endsequence
  property p_expire;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_fire |=> o_cpu_rst && !o_irq;
  endproperty
  a_expire: assert property (p_expire) else $error("no reset at timeout"); // RULE4

  property p_irq_sel;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_irq |-> $past(sel_q) == IWD_ACT_IRQ;
  endproperty
  a_irq_sel: assert property (p_irq_sel) else $error("irq without selection"); // RULE6

  property p_idle_quiet;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == IWD_IDLE) |-> ticks_q == '0 && !expired;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle timer counts"); // RULE10

  property p_restart;
    @(posedge i_ref_clk) disable iff (i_rst)
      (do_arm && !do_dis) |=> ticks_q == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("refresh kept old count"); // RULE10

  property p_default;
    @(posedge i_ref_clk) disable iff (i_rst)
      $fell(i_rst) |-> sel_q == IWD_ACT_RESET;
  endproperty
  a_default: assert property (p_default) else $error("default action not reset"); // RULE7

  property p_pulse_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == IWD_FIRE && !do_dis && !do_arm && !pulse_last) |=> (o_cpu_rst || o_irq);
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("expiry pulse cut short"); // RULE4

  sequence s_fire_irq;
    expired && !do_dis && !do_arm && sel_q == IWD_ACT_IRQ;
  endsequence
  property p_expire_irq;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_fire_irq |=> o_irq && !o_cpu_rst;
  endproperty
  a_expire_irq: assert property (p_expire_irq) else $error("no interrupt at timeout"); // RULE6

  property p_one_action;
    @(posedge i_ref_clk) disable iff (i_rst)
      !(o_cpu_rst && o_irq);
  endproperty
  a_one_action: assert property (p_one_action) else $error("both actions at once"); // RULE6

  property p_idle_silent;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == IWD_IDLE) |=> !o_cpu_rst && !o_irq;
  endproperty
  a_idle_silent: assert property (p_idle_silent) else $error("idle timer acts"); // RULE10

  property p_foreign_addr;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == IWD_IDLE && !hit) |=> state_q == IWD_IDLE;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("other port armed timer"); // RULE1

  property p_run_enabled;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == IWD_RUN && !do_dis) |=> o_enabled;
  endproperty
  a_run_enabled: assert property (p_run_enabled) else $error("running timer not shown"); // RULE1
endmodule

// ===== verilog/iwd_pkg.sv
// Package with port address, data codes and timing for the I/O port watchdog
package iwd_pkg;
  localparam logic [15:0] IWD_PORT_ADDR     = 16'h0443;
  localparam logic [7:0]  IWD_CMD_DISABLE   = 8'h00;
  localparam logic [7:0]  IWD_CMD_REFRESH   = 8'h01;
  localparam int          IWD_CLK_HZ        = 100_000_000;
  localparam int          IWD_TIMEOUT_MS    = 1600;
  localparam longint      IWD_TIMEOUT_CYC   = longint'(IWD_CLK_HZ) / 1000 * IWD_TIMEOUT_MS;
  localparam int          IWD_TICK_US       = 1;
  localparam int          IWD_TICK_CYC      = IWD_CLK_HZ / 1_000_000 * IWD_TICK_US;
  localparam int          IWD_TIMEOUT_TICKS = int'(IWD_TIMEOUT_CYC / IWD_TICK_CYC);
  localparam int          IWD_RST_PULSE_CYC = 16;
  localparam logic        IWD_ACT_RESET     = 1'b0;
  localparam logic        IWD_ACT_IRQ       = 1'b1;
  typedef enum logic [1:0] {IWD_IDLE, IWD_RUN, IWD_FIRE} iwd_state_type;
endpackage

// ===== verilog/iwd_tick.sv
// Divider producing a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module iwd_tick #(
  parameter int DIV = 100
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Restart and tick
  input  wire logic i_restart,
  output logic      o_tick
);
  logic [31:0] cnt_q;
  wire         at_end = (cnt_q == 32'(DIV - 1));

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_restart || at_end) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= at_end && !i_restart;
    end
  end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the I/O port watchdog
`timescale 1ns/1ps
module testbench;
  import iwd_pkg::*;
  logic        ref_clk, rst, io_wr, io_rd, act_sel, chk_rd, rd_pend, rst_p, irq_p;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, q[$];
  logic        cpu_rst, irq, enabled;
  int          fails, n_checks, cyc;

  iwd_watchdog #(.TIMEOUT_TICKS(5), .TICK_CYC(2), .RST_PULSE_CYC(IWD_RST_PULSE_CYC)) DUT (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_io_addr(io_addr), .i_io_wr(io_wr),
    .i_io_rd(io_rd), .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
    .i_act_irq_sel(act_sel), .o_cpu_rst(cpu_rst), .o_irq(irq), .o_enabled(enabled));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task results;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Port access; a checked read queues its expected data
  task io(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic chk,
          input logic [7:0] e);
    if (chk) q.push_back(e);
    @(posedge ref_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= wr;
    io_rd    <= !wr;
    chk_rd   <= chk & !wr;
    @(posedge ref_clk);
    io_wr  <= 1'b0;
    io_rd  <= 1'b0;
    chk_rd <= 1'b0;
  endtask

  // Queue an expiry code, then wait for the pulse to come and go
  task fire(input logic [7:0] e);
    int n;
    q.push_back(e);
    n = 0;
    while (!(cpu_rst | irq) && n < 60) begin @(negedge ref_clk); n++; end
    n = 0;
    while ((cpu_rst | irq) && n < 60) begin @(negedge ref_clk); n++; end
    check(8'(n), 8'(IWD_RST_PULSE_CYC));
  endtask

  // Result watcher: read data and expiry pulse starts
  always @(posedge ref_clk) begin
    if (rd_pend) check(io_rdata, q.size() ? q.pop_front() : 8'hee);
    if ((cpu_rst && !rst_p) || (irq && !irq_p))
      check({6'h20, irq, cpu_rst}, q.size() ? q.pop_front() : 8'hee);
    rd_pend <= chk_rd;
    rst_p   <= cpu_rst;
    irq_p   <= irq;
    cyc     <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end

  initial begin
    {io_wr, io_rd, act_sel, chk_rd} = '0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    rst = 1'b1;
    void'($urandom(60));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check({7'h0, enabled}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      io(1'b1, IWD_PORT_ADDR ^ (16'h0001 << ($urandom % 16)), IWD_CMD_REFRESH, 1'b0, 8'h00);
      io(1'b1, IWD_PORT_ADDR, 8'h02 + 8'($urandom % 254), 1'b0, 8'h00);
    end
    @(negedge ref_clk);
    check({7'h0, enabled}, 8'h00);
    io(1'b0, IWD_PORT_ADDR, 8'h00, 1'b1, 8'h00);
    repeat (2) @(negedge ref_clk);
    check({7'h0, enabled}, 8'h01);
    io(1'b0, IWD_PORT_ADDR, 8'h00, 1'b1, 8'h01);
    fire(8'h81);
    check({7'h0, enabled}, 8'h00);
    io(1'b1, IWD_PORT_ADDR, IWD_CMD_REFRESH, 1'b0, 8'h00);
    repeat (12) begin
      repeat ($urandom % 6) @(posedge ref_clk);
      io(1'b1, IWD_PORT_ADDR, IWD_CMD_REFRESH, 1'b0, 8'h00);
    end
    io(1'b0, IWD_PORT_ADDR, 8'h00, 1'b1, 8'h01);
    fire(8'h81);
    io(1'b1, IWD_PORT_ADDR, IWD_CMD_REFRESH, 1'b0, 8'h00);
    io(1'b1, IWD_PORT_ADDR, IWD_CMD_DISABLE, 1'b0, 8'h00);
    repeat (40) @(negedge ref_clk);
    check({7'h0, enabled}, 8'h00);
    @(posedge ref_clk);
    act_sel <= 1'b1;
    repeat (4) @(posedge ref_clk);
    io(1'b1, IWD_PORT_ADDR, IWD_CMD_REFRESH, 1'b0, 8'h00);
    fire(8'h82);
    @(posedge ref_clk);
    act_sel <= 1'b0;
    repeat (4) @(negedge ref_clk);
    check(8'(q.size()), 8'h00);
    results();
  end
endmodule
